// File: strap_map.svh
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_FREQ_HZ 200000000
`define TICK_PERIOD_US 1000
`define TICK_CYCLES_DEF ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)
`define STORE_HOLD_MS 1000

// ----------------------------------------
// dwell periods in milliseconds, by index
// ----------------------------------------
`define DWELL0_MS 20'h000c8
`define DWELL1_MS 20'h003e8
`define DWELL2_MS 20'h007d0
`define DWELL3_MS 20'h01388
`define DWELL4_MS 20'h02710
`define DWELL5_MS 20'h07530
`define DWELL6_MS 20'h0ea60
`define DWELL7_MS 20'h1d4c0
`define DWELL8_MS 20'h493e0
`define DWELL9_MS 20'h927c0

// ----------------------------------------
// level pad codes and settings
// ----------------------------------------
`define LVL_2K7 3'h0
`define LVL_6K8 3'h1
`define LVL_GND 3'h2
`define LVL_15K 3'h3
`define LVL_39K 3'h4
`define SENS_DEFAULT 3'h2
`define SENS_MAX 3'h4
`define DWELL_DEFAULT 4'h1
`define DWELL_SHORTEST 4'h0
`define DWELL_MAX 4'h9
`define MODE_RETRIG 1'b0
`define MODE_SINGLE 1'b1

// ----------------------------------------
// register map
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define CTRL_MOTION_EN_BIT 0
`define CTRL_RESET 1'b1

`endif

// File: strap_pkg.sv
package strap_pkg;
`include "strap_map.svh"

    typedef logic [2:0] level_code_t;

    typedef struct packed {
        logic mode;
        logic [3:0] dwell;
        logic [2:0] sens;
    } settings_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_ARMED = 2'b10
    } store_state_t;

    typedef enum logic [1:0] {
        T_OFF = 2'b00,
        T_ON = 2'b01,
        T_LOCK = 2'b10
    } timer_state_t;

    localparam settings_t SETTINGS_DEFAULT =
        '{`MODE_RETRIG, `DWELL_DEFAULT, `SENS_DEFAULT};

    function automatic logic [19:0] dwell_ms(input logic [3:0] idx);
        logic [19:0] ms;
        ms = `DWELL1_MS;
        case (idx)
            4'h0: ms = `DWELL0_MS;
            4'h2: ms = `DWELL2_MS;
            4'h3: ms = `DWELL3_MS;
            4'h4: ms = `DWELL4_MS;
            4'h5: ms = `DWELL5_MS;
            4'h6: ms = `DWELL6_MS;
            4'h7: ms = `DWELL7_MS;
            4'h8: ms = `DWELL8_MS;
            4'h9: ms = `DWELL9_MS;
            default: ms = `DWELL1_MS;
        endcase
        return ms;
    endfunction
endpackage

// File: settings_if.sv
`timescale 1ns/1ps
interface settings_if;
    import strap_pkg::*;
    logic tick;
    logic motion;
    logic mode;
    logic [3:0] dwell;
    logic active;

    modport cfg(input tick, input active,
        output motion, output mode, output dwell);
    modport ticker(output tick);
    modport timer(input tick, input motion, input mode, input dwell,
        output active);
endinterface

// File: ms_tick_divider.sv
`timescale 1ns/1ps
`include "strap_map.svh"
module ms_tick_divider #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    settings_if.ticker bus
);
    localparam int W = $clog2(TICK_CYCLES);

    logic [W-1:0] cnt_reg;
    logic tick_reg;

    if (TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end

    // ----------------------------------------
    // one-cycle pulse every tick period
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= (cnt_reg == W'(TICK_CYCLES - 1));
            cnt_reg <= (cnt_reg == W'(TICK_CYCLES - 1)) ? '0 :
                cnt_reg + W'(1);
        end
    end

    assign bus.tick = tick_reg;
endmodule

// File: dwell_output_timer.sv
`timescale 1ns/1ps
`include "strap_map.svh"
module dwell_output_timer
    import strap_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    settings_if.timer bus
);
    timer_state_t t_st;
    logic [19:0] cnt_reg;
    logic [19:0] limit;
    logic retrig_hit;
    logic expire;

    assign limit = dwell_ms(bus.dwell);
    assign retrig_hit = bus.motion && (bus.mode == `MODE_RETRIG) &&
        (bus.dwell != `DWELL_SHORTEST);
    assign expire = bus.tick && (cnt_reg >= limit - 20'h1);

    // ----------------------------------------
    // output state machine
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            t_st <= T_OFF;
            cnt_reg <= '0;
        end
        else
        begin
            unique case (t_st)
                T_OFF:
                begin
                    cnt_reg <= '0;
                    if (bus.motion)
                        t_st <= T_ON;
                end
                T_ON:
                begin
                    if (retrig_hit)
                        cnt_reg <= '0;
                    else if (expire)
                    begin
                        cnt_reg <= '0;
                        t_st <= (bus.mode == `MODE_SINGLE) ? T_LOCK :
                            T_OFF;
                    end
                    else if (bus.tick)
                        cnt_reg <= cnt_reg + 20'h1;
                end
                T_LOCK:
                begin
                    if (!bus.motion)
                        t_st <= T_OFF;
                end
                default: t_st <= T_OFF;
            endcase
        end
    end

    assign bus.active = (t_st == T_ON);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_retrig_restart: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (t_st == T_ON && retrig_hit) |=> (cnt_reg == 20'h0 && bus.active))
        else $error("retrigger did not restart dwell");
    chk_short_no_retrig: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (t_st == T_ON && bus.dwell == `DWELL_SHORTEST && bus.tick &&
        !expire) |=> cnt_reg == $past(cnt_reg) + 20'h1)
        else $error("shortest dwell restarted");
    chk_single_lockout: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (t_st == T_ON && expire && !retrig_hit &&
        bus.mode == `MODE_SINGLE) |=> !bus.active ##1 (!bus.active ||
        !$past(bus.motion)))
        else $error("single event output not locked out");
    chk_idle_low: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (t_st != T_ON && !bus.motion) |=> !bus.active)
        else $error("output high without motion");
endmodule

// File: strap_setting_programmer.sv
`timescale 1ns/1ps
`include "strap_map.svh"
module strap_setting_programmer
    import strap_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_select_pad_a_b,
    input wire logic i_select_pad_b_b,
    input wire logic i_store_pad_b,
    input wire logic [2:0] i_level_code,
    input wire logic i_motion,
    input wire logic i_nv_load,
    input wire logic [7:0] i_nv_word,
    output logic o_nv_write,
    output logic [7:0] o_nv_word,
    output logic o_motion_out,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp
);
    settings_if bus();

    // ----------------------------------------
    // pad synchronisers
    // ----------------------------------------
    logic [5:0] pin_raw;
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;

    assign pin_raw = {i_level_code, i_store_pad_b, i_select_pad_b_b,
        i_select_pad_a_b};

    for (genvar g = 0; g < 6; g++)
    begin : g_sync
        always_ff @(posedge i_clk or negedge i_rst_b)
        begin
            if (!i_rst_b)
            begin
                sync1_reg[g] <= 1'b1;
                sync2_reg[g] <= 1'b1;
            end
            else
            begin
                sync1_reg[g] <= pin_raw[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end

    logic a_gnd;
    logic b_gnd;
    logic store_low;
    level_code_t level_now;

    assign a_gnd = !sync2_reg[0];
    assign b_gnd = !sync2_reg[1];
    assign store_low = !sync2_reg[2];
    assign level_now = sync2_reg[5:3];

    // ----------------------------------------
    // store pad hold and release
    // ----------------------------------------
    store_state_t st_reg;
    logic [9:0] hold_ms_reg;
    logic commit;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_reg <= ST_IDLE;
            hold_ms_reg <= '0;
        end
        else
        begin
            unique case (st_reg)
                ST_IDLE:
                begin
                    hold_ms_reg <= '0;
                    if (store_low)
                        st_reg <= ST_HOLD;
                end
                ST_HOLD:
                begin
                    if (!store_low)
                        st_reg <= ST_IDLE;
                    else if (bus.tick)
                    begin
                        if (hold_ms_reg == 10'(`STORE_HOLD_MS - 1))
                            st_reg <= ST_ARMED;
                        else
                            hold_ms_reg <= hold_ms_reg + 10'h1;
                    end
                end
                ST_ARMED:
                begin
                    if (!store_low)
                        st_reg <= ST_IDLE;
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    assign commit = (st_reg == ST_ARMED) && !store_low;

    // ----------------------------------------
    // strap capture at acceptance
    // ----------------------------------------
    logic lat_a_reg;
    logic lat_b_reg;
    level_code_t lat_level_reg;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            lat_a_reg <= 1'b0;
            lat_b_reg <= 1'b0;
            lat_level_reg <= `LVL_GND;
        end
        else if (st_reg == ST_HOLD && store_low && bus.tick &&
            hold_ms_reg == 10'(`STORE_HOLD_MS - 1))
        begin
            lat_a_reg <= a_gnd;
            lat_b_reg <= b_gnd;
            lat_level_reg <= level_now;
        end
    end

    // ----------------------------------------
    // strap decode
    // ----------------------------------------
    settings_t set_reg;
    settings_t set_next;
    logic cmd_ok;

    always_comb
    begin
        set_next = set_reg;
        cmd_ok = 1'b1;
        unique case ({lat_a_reg, lat_b_reg})
            2'b00:
            begin
                if (lat_level_reg <= `SENS_MAX)
                    set_next.sens = lat_level_reg;
                else
                    cmd_ok = 1'b0;
            end
            2'b10:
            begin
                unique case (lat_level_reg)
                    `LVL_2K7: set_next.dwell = 4'h0;
                    `LVL_GND: set_next.dwell = 4'h1;
                    `LVL_6K8: set_next.dwell = 4'h2;
                    `LVL_15K: set_next.dwell = 4'h3;
                    `LVL_39K: set_next.dwell = 4'h4;
                    default: cmd_ok = 1'b0;
                endcase
            end
            2'b01:
            begin
                unique case (lat_level_reg)
                    `LVL_GND: set_next.dwell = 4'h5;
                    `LVL_2K7: set_next.dwell = 4'h6;
                    `LVL_6K8: set_next.dwell = 4'h7;
                    `LVL_15K: set_next.dwell = 4'h8;
                    `LVL_39K: set_next.dwell = 4'h9;
                    default: cmd_ok = 1'b0;
                endcase
            end
            2'b11:
            begin
                unique case (lat_level_reg)
                    `LVL_2K7: set_next.mode = `MODE_RETRIG;
                    `LVL_6K8: set_next.mode = `MODE_SINGLE;
                    `LVL_GND: set_next = SETTINGS_DEFAULT;
                    default: cmd_ok = 1'b0;
                endcase
            end
        endcase
    end

    // ----------------------------------------
    // settings and storage write-back
    // ----------------------------------------
    logic nv_ok;
    logic nv_write_reg;
    logic [7:0] nv_word_reg;

    assign nv_ok = (i_nv_word[2:0] <= `SENS_MAX) &&
        (i_nv_word[6:3] <= `DWELL_MAX);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            set_reg <= SETTINGS_DEFAULT;
        else if (commit && cmd_ok)
            set_reg <= set_next;
        else if (i_nv_load)
            set_reg <= nv_ok ? settings_t'(i_nv_word) :
                SETTINGS_DEFAULT;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            nv_write_reg <= 1'b0;
            nv_word_reg <= SETTINGS_DEFAULT;
        end
        else
        begin
            nv_write_reg <= commit && cmd_ok;
            if (commit && cmd_ok)
                nv_word_reg <= set_next;
        end
    end

    assign o_nv_write = nv_write_reg;
    assign o_nv_word = nv_word_reg;

    // ----------------------------------------
    // register bus slave
    // ----------------------------------------
    logic aphase;
    logic dp_wr_reg;
    logic [7:0] dp_addr_reg;
    logic ctrl_reg;
    logic ctrl_view;
    logic [31:0] rdata_reg;
    logic [31:0] status_word;

    assign aphase = i_hsel && i_hready && i_htrans[1];
    assign ctrl_view = (dp_wr_reg && dp_addr_reg == `REG_CTRL) ?
        i_hwdata[`CTRL_MOTION_EN_BIT] : ctrl_reg;
    assign status_word = {21'h0, bus.active, st_reg, set_reg};

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= '0;
        end
        else
        begin
            dp_wr_reg <= aphase && i_hwrite;
            dp_addr_reg <= {i_haddr[7:2], 2'b00};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            ctrl_reg <= `CTRL_RESET;
        else if (dp_wr_reg && dp_addr_reg == `REG_CTRL)
            ctrl_reg <= i_hwdata[`CTRL_MOTION_EN_BIT];
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rdata_reg <= '0;
        else if (aphase && !i_hwrite)
        begin
            unique case ({i_haddr[7:2], 2'b00})
                `REG_CTRL: rdata_reg <= {31'h0, ctrl_view};
                `REG_STATUS: rdata_reg <= status_word;
                default: rdata_reg <= '0;
            endcase
        end
    end

    assign o_hrdata = rdata_reg;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    // ----------------------------------------
    // timing and output
    // ----------------------------------------
    assign bus.motion = i_motion && ctrl_reg;
    assign bus.mode = set_reg.mode;
    assign bus.dwell = set_reg.dwell;

    ms_tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_div (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .bus(bus.ticker)
    );

    dwell_output_timer u_timer (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .bus(bus.timer)
    );

    assign o_motion_out = bus.active;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_short_store: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (st_reg == ST_HOLD && !store_low && !i_nv_load) |=>
        (!o_nv_write && $stable(set_reg)))
        else $error("short store changed settings");
    chk_commit_write: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (commit && cmd_ok) |=> (o_nv_write && set_reg == $past(set_next)))
        else $error("accepted store not committed");
    chk_arm_after_hold: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (st_reg != ST_ARMED ##1 st_reg == ST_ARMED) |->
        $past(hold_ms_reg) == 10'(`STORE_HOLD_MS - 1))
        else $error("store armed before full hold");
    chk_restore_all: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (commit && lat_a_reg && lat_b_reg && lat_level_reg == `LVL_GND)
        |=> set_reg == SETTINGS_DEFAULT)
        else $error("restore did not set defaults");
    chk_single_setting: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (commit && !lat_a_reg && !lat_b_reg) |=>
        ($stable(set_reg.dwell) && $stable(set_reg.mode)))
        else $error("sensitivity store touched other settings");
    chk_hold_settings: assert property (@(posedge i_clk)
        disable iff (!i_rst_b)
        (!(commit && cmd_ok) && !i_nv_load) |=> $stable(set_reg))
        else $error("settings changed without a store");
endmodule

// File: strap_fixture.sv
`timescale 1ns/1ps
module strap_fixture #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    output logic o_select_pad_a_b,
    output logic o_select_pad_b_b,
    output logic o_store_pad_b,
    output logic [2:0] o_level_code
);
    // ------
    // pads open, no resistor fitted
    // ------
    initial
    begin
        o_select_pad_a_b = 1'b1;
        o_select_pad_b_b = 1'b1;
        o_store_pad_b = 1'b1;
        o_level_code = 3'h7;
    end

    // ------
    // strap, hold store, release, unstrap
    // ------
    task automatic store(input logic a_b, input logic b_b,
        input logic [2:0] lvl, input int ticks);
        while (i_rst_b !== 1'b1)
            @(posedge i_clk);
        @(posedge i_clk);
        o_select_pad_a_b <= a_b;
        o_select_pad_b_b <= b_b;
        o_level_code <= lvl;
        repeat (16) @(posedge i_clk);
        o_store_pad_b <= 1'b0;
        repeat (ticks * TICK_CYCLES + 16) @(posedge i_clk);
        o_store_pad_b <= 1'b1;
        repeat (16) @(posedge i_clk);
        o_select_pad_a_b <= 1'b1;
        o_select_pad_b_b <= 1'b1;
        o_level_code <= 3'h7;
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import strap_pkg::*;
    // ------
    // signals and instances
    // ------
    logic i_clk, i_rst_b, i_motion, i_nv_load, i_hwrite;
    logic a_b, b_b, st_b, o_nv_write, o_motion_out, o_hreadyout, o_hresp;
    logic [2:0] lvl;
    logic [7:0] i_nv_word, o_nv_word;
    logic [1:0] i_htrans;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, d;
    logic [4:0] dc [10] = '{5'h0a, 5'h09, 5'h0b, 5'h0c, 5'h12,
        5'h10, 5'h11, 5'h13, 5'h14, 5'h08};
    logic [3:0] dx [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
        4'h6, 4'h7, 4'h8, 4'h9, 4'h0};
    int n_mismatch = 0;
    int compares = 0;
    int pulses = 0;

    strap_setting_programmer #(.TICK_CYCLES(4)) i_strap_setting_programmer (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_select_pad_a_b(a_b),
        .i_select_pad_b_b(b_b), .i_store_pad_b(st_b), .i_level_code(lvl),
        .i_motion(i_motion), .i_nv_load(i_nv_load), .i_nv_word(i_nv_word),
        .o_nv_write(o_nv_write), .o_nv_word(o_nv_word),
        .o_motion_out(o_motion_out), .i_hsel(1'b1), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp));

    strap_fixture #(.TICK_CYCLES(4)) i_strap_fixture (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .o_select_pad_a_b(a_b),
        .o_select_pad_b_b(b_b), .o_store_pad_b(st_b), .o_level_code(lvl));

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
        if (o_nv_write === 1'b1)
            pulses++;

    // ------
    // shared tasks
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a,
        input logic [31:0] wd);
        i_htrans <= 2'h2;
        i_haddr <= a;
        i_hwrite <= wr;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        d = o_hrdata;
    endtask

    task automatic st(input logic a, input logic b, input logic [2:0] l,
        input int t, input int ok, input logic [7:0] exp);
        int p0;
        p0 = pulses;
        i_strap_fixture.store(a, b, l, t);
        check(pulses - p0, ok, "commit pulse count");
        ahb(1'b0, 32'h4, 32'h0);
        check(d[7:0], exp, "stored settings");
        check(o_nv_word, exp, "storage image");
    endtask

    task automatic nv(input logic [7:0] w, input logic [7:0] exp);
        i_nv_load <= 1'b1;
        i_nv_word <= w;
        cyc(1);
        i_nv_load <= 1'b0;
        cyc(1);
        ahb(1'b0, 32'h4, 32'h0);
        check(d[7:0], exp, "power-up restore");
    endtask

    task automatic pulse_m();
        i_motion <= 1'b1;
        cyc(1);
        i_motion <= 1'b0;
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------
    // scenarios
    // ------
    task automatic t_reset();
        check(o_nv_word, 8'h0a, "reset image");
        check(o_motion_out, 1'b0, "idle output");
        check(o_hreadyout, 1'b1, "slave always ready");
        check(o_hresp, 1'b0, "slave always okay");
        ahb(1'b0, 32'h4, 32'h0);
        check(d[7:0], 8'h0a, "default settings");
        ahb(1'b1, 32'h8, 32'h5);
        ahb(1'b0, 32'h8, 32'h0);
        check(d, 32'h0, "unmapped read");
        ahb(1'b0, 32'h0, 32'h0);
        check(d, 32'h1, "enable reset value");
    endtask

    task automatic t_noretrig();
        pulse_m();
        cyc(2);
        check(o_motion_out, 1'b1, "output on");
        cyc(400);
        pulse_m();
        cyc(600);
        check(o_motion_out, 1'b0, "shortest dwell retriggered");
    endtask

    task automatic t_single();
        i_motion <= 1'b1;
        cyc(3);
        check(o_motion_out, 1'b1, "single on");
        cyc(700);
        check(o_motion_out, 1'b1, "single held");
        cyc(400);
        check(o_motion_out, 1'b0, "single past dwell");
        i_motion <= 1'b0;
        cyc(2);
        i_motion <= 1'b1;
        cyc(3);
        check(o_motion_out, 1'b1, "single rearmed");
        i_motion <= 1'b0;
        cyc(900);
    endtask

    task automatic t_retrig();
        ahb(1'b1, 32'h0, 32'h0);
        pulse_m();
        cyc(3);
        check(o_motion_out, 1'b0, "motion disabled");
        ahb(1'b1, 32'h0, 32'h1);
        pulse_m();
        cyc(3000);
        pulse_m();
        cyc(2000);
        check(o_motion_out, 1'b1, "retriggered");
        cyc(2500);
        check(o_motion_out, 1'b0, "output off");
    endtask

    // ------
    // main sequence and watchdog
    // ------
    initial
    begin
        i_rst_b = 1'b0;
        i_motion = 1'b0;
        i_nv_load = 1'b0;
        i_nv_word = 8'h00;
        i_htrans = 2'h0;
        i_haddr = 32'h0;
        i_hwrite = 1'b0;
        i_hwdata = 32'h0;
        cyc(5);
        i_rst_b <= 1'b1;
        cyc(1);
        t_reset();
        nv(8'h99, 8'h99);
        nv(8'hff, 8'h0a);
        nv(8'h99, 8'h99);
        for (int i = 0; i < 5; i++)
            st(1'b1, 1'b1, i[2:0], 1000, 1, {5'h13, i[2:0]});
        for (int i = 0; i < 10; i++)
            st(dc[i][4], dc[i][3], dc[i][2:0], 1000, 1,
                {1'b1, dx[i], 3'h4});
        st(1'b1, 1'b1, 3'h0, 500, 0, 8'h84);
        st(1'b0, 1'b0, 3'h3, 1000, 0, 8'h84);
        st(1'b0, 1'b0, 3'h0, 1000, 1, 8'h04);
        t_noretrig();
        st(1'b0, 1'b0, 3'h1, 1000, 1, 8'h84);
        t_single();
        st(1'b0, 1'b0, 3'h2, 1000, 1, 8'h0a);
        t_retrig();
        close_out();
    end

    initial
    begin
        #500000;
        n_mismatch++;
        close_out();
    end
endmodule
